// ### verilog/csd_cfg.svh
// Purpose: Offsets, field positions, reset values of the chip-select decoder
// Assumes: Byte addresses on a 32-bit register port
// Notes:   Definitions only
`ifndef CSD_CFG_SVH
`define CSD_CFG_SVH

// Register byte addresses
`define CSD_OFS_REGION0      32'hFFFFE400
`define CSD_OFS_REGION1      32'hFFFFE404
`define CSD_OFS_REGION2      32'hFFFFE408
`define CSD_OFS_REGION3      32'hFFFFE40C
`define CSD_OFS_CTRL         32'hFFFFE410

// Field positions of a base/mask register
`define CSD_BASE_MSB         31
`define CSD_BASE_LSB         16
`define CSD_MASK_MSB         15
`define CSD_MASK_LSB         0

// Lowest maskable address bit per region pair
`define CSD_LO_PAIR_SHIFT    14
`define CSD_HI_PAIR_SHIFT    15

// Control register fields
`define CSD_CTRL_EN_LSB      0
`define CSD_CTRL_FULL_BIT    4

// Reset values
`define CSD_RST_REGION_LO    32'h000003FF
`define CSD_RST_REGION_HI    32'h000001FF
`define CSD_RST_ENABLE       4'h4
`define CSD_RST_FULL         1'h1

`endif

// ### verilog/csd_pkg.sv
// Purpose: Types of the chip-select decoder
// Assumes: Four select regions
// Notes:   Constants live in csd_cfg.svh
package csd_pkg;

	// Register port request
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} csd_reg_req_t;

	// Bus cycle presented by core or dma
	typedef struct packed {
		logic [31:0] addr;
		logic        valid;
	} csd_bus_cyc_t;

	// Whole state of the decoder
	typedef struct packed {
		logic [3:0][31:0] region_base_mask;
		logic [3:0]       enable;
		logic             full_space;
		logic [31:0]      rdata;
		logic [3:0]       select;
	} csd_state_t;

endpackage

// ### verilog/csd_decoder.sv
// Purpose: Four-region chip-select address decoder with register port
// Assumes: Bus addresses come from logic on clk_in, physical addresses
// Notes:   Selects are registered, one cycle after the bus cycle
//
// Chosen here: strobed register access.
`include "csd_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Base field bits 31..16 give address bits 31..16 of the region start.
// - Start address bits 15..0 are zero, so regions sit on 64 KB boundaries.
// - A mask bit of one drops its address bit from the compare.
// - Every bus cycle is compared against all regions.
// - Regions zero and one mask address bits 29..14 only.
// - Regions two and three mask address bits 30..15 only.
// - Regions zero and one span 16 KB up to 1 GB.
// - Regions zero and one reset with mask bits 9..0 set, all else clear.
// - Mask field sits in bits 15..0 and sets the block size.
// - Regions zero and one always compare address bits 31 and 30.
// - After reset only region two is enabled and it covers all 4 GB.
// - A select fires only for a core or dma address inside its range.
module csd_decoder
	import csd_pkg::*;
#(
	parameter int NUM_SEL = 4
) (
	// Clock and reset
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	// Register port
	input  wire csd_reg_req_t reg_req_in,
	output logic [31:0]       reg_rdata_out,
	// Bus cycle from core or dma
	input  wire csd_bus_cyc_t bus_cyc_in,
	// Select lines, active high
	output logic [3:0]        select_out
);

	////////////////////////////////////////////////////////////////////////
	// Elaboration check
	if (NUM_SEL != 4) begin : g_bad_num
		$error("csd_decoder serves exactly four selects");
	end

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Start address of a region from its register
	function automatic logic [31:0] region_start(input logic [31:0] bm);
		region_start = {bm[`CSD_BASE_MSB:`CSD_BASE_LSB], 16'h0000};
	endfunction

	// Address bits that take part in the compare
	function automatic logic [31:0] compare_bits(input logic [31:0] bm, input logic hi_pair);
		logic [31:0] ign;
		logic [15:0] msk;
		msk = bm[`CSD_MASK_MSB:`CSD_MASK_LSB];
		if (hi_pair) begin
			ign = {1'b0, msk, 15'h7FFF};
		end else begin
			ign = {2'b00, msk, 14'h3FFF};
		end
		compare_bits = ~ign;
	endfunction

	// Match test of one address against one region
	function automatic logic region_hit(input logic [31:0] a, input logic [31:0] bm,
		input logic hi_pair);
		region_hit = (((a ^ region_start(bm)) & compare_bits(bm, hi_pair)) == 32'h00000000);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State
	csd_state_t st_q;
	csd_state_t st_d;
	logic [31:0] offs [4];

	assign offs[0] = `CSD_OFS_REGION0;
	assign offs[1] = `CSD_OFS_REGION1;
	assign offs[2] = `CSD_OFS_REGION2;
	assign offs[3] = `CSD_OFS_REGION3;

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic [3:0] hit;
		st_d = st_q;
		hit = 4'h0;
		// Register writes
		if (reg_req_in.wr) begin
			for (int i = 0; i < 4; i++) begin
				if (reg_req_in.addr == offs[i]) begin
					st_d.region_base_mask[i] = reg_req_in.wdata;
				end
			end
			if (reg_req_in.addr == `CSD_OFS_CTRL) begin
				st_d.enable = reg_req_in.wdata[`CSD_CTRL_EN_LSB +: 4];
				st_d.full_space = reg_req_in.wdata[`CSD_CTRL_FULL_BIT];
			end
		end
		// Read data stands only in the cycle after the strobe
		st_d.rdata = 32'h00000000;
		if (reg_req_in.rd) begin
			for (int i = 0; i < 4; i++) begin
				if (reg_req_in.addr == offs[i]) begin
					st_d.rdata = st_q.region_base_mask[i];
				end
			end
			if (reg_req_in.addr == `CSD_OFS_CTRL) begin
				st_d.rdata = {27'h0000000, st_q.full_space, st_q.enable};
			end
		end
		// Compare every bus cycle against every region
		for (int i = 0; i < 4; i++) begin
			hit[i] = region_hit(bus_cyc_in.addr, st_q.region_base_mask[i], (i >= 2));
		end
		hit[2] = hit[2] | st_q.full_space;
		hit = hit & st_q.enable;
		// Lowest index wins on overlap
		st_d.select = 4'h0;
		if (bus_cyc_in.valid) begin
			for (int i = 3; i >= 0; i--) begin
				if (hit[i]) begin
					st_d.select = 4'h1 << i;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q.region_base_mask[0] <= `CSD_RST_REGION_LO;
			st_q.region_base_mask[1] <= `CSD_RST_REGION_LO;
			st_q.region_base_mask[2] <= `CSD_RST_REGION_HI;
			st_q.region_base_mask[3] <= `CSD_RST_REGION_HI;
			st_q.enable <= `CSD_RST_ENABLE;
			st_q.full_space <= `CSD_RST_FULL;
			st_q.rdata <= 32'h00000000;
			st_q.select <= 4'h0;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata_out = st_q.rdata;
	assign select_out = st_q.select;

endmodule

`default_nettype wire

// ### tb/csd_decoder_chk.sv
// Purpose: Port checks of the decoder
// Assumes: Region zero and its enable shadowed here
// Notes:   Bound below
`timescale 1ns/1ns
`default_nettype none
module csd_chk
	import csd_pkg::*;
(
	input wire logic         clk_in,
	input wire logic         rst_n_in,
	input wire csd_reg_req_t reg_req_in,
	input wire logic [31:0]  reg_rdata_out,
	input wire csd_bus_cyc_t bus_cyc_in,
	input wire logic [3:0]   select_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	logic [31:0] r0_q;
	logic        en0_q;
	wire logic   hit0 = !((bus_cyc_in.addr ^ {r0_q[31:16], 16'h0000})
		& ~{2'h0, r0_q[15:0], 14'h3FFF});
	// Shadow of region zero and its enable
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			r0_q <= 32'h000003FF;
			en0_q <= 1'h0;
		end else if (reg_req_in.wr && reg_req_in.addr == 32'hFFFFE400)
			r0_q <= reg_req_in.wdata;
		else if (reg_req_in.wr && reg_req_in.addr == 32'hFFFFE410)
			en0_q <= reg_req_in.wdata[0];
	end
	property p_idl; !bus_cyc_in.valid |=> !select_out; endproperty
	a_idl: assert property (p_idl) else $error("select idle");
	property p_one; $onehot0(select_out); endproperty
	a_one: assert property (p_one) else $error("select hot");
	property p_src; |select_out |-> $past(bus_cyc_in.valid); endproperty
	a_src: assert property (p_src) else $error("select source");
	property p_mis; bus_cyc_in.valid && !hit0 |=> !select_out[0]; endproperty
	a_mis: assert property (p_mis) else $error("region miss");
	property p_hit; bus_cyc_in.valid && hit0 && en0_q |=> select_out == 4'h1; endproperty
	a_hit: assert property (p_hit) else $error("region hit");
	property p_rdz; !reg_req_in.rd |=> !reg_rdata_out; endproperty
	a_rdz: assert property (p_rdz) else $error("read idle");
	property p_rd0; reg_req_in.rd && reg_req_in.addr == 32'hFFFFE400 |=> reg_rdata_out == r0_q;
	endproperty
	a_rd0: assert property (p_rd0) else $error("read region");
	property p_map; reg_req_in.rd && reg_req_in.addr > 32'hFFFFE410 |=> !reg_rdata_out; endproperty
	a_map: assert property (p_map) else $error("read unmapped");
endmodule
bind csd_decoder csd_chk i_csd_chk (.clk_in, .rst_n_in, .reg_req_in, .reg_rdata_out,
	.bus_cyc_in, .select_out);
`default_nettype wire

// ### tb/csd_bus_src.sv
// Purpose: Core or dma side presenting bus cycles
// Assumes: Bench holds the address between cycles
// Notes:   Idle address is the inverse of the held one
`timescale 1ns/1ns
`default_nettype none
module csd_bus_src
	import csd_pkg::*;
(
	input  wire logic        go_in,
	input  wire logic [31:0] addr_in,
	output var csd_bus_cyc_t bus_cyc_out
);
	// Physical address only while a cycle is presented
	assign bus_cyc_out = {go_in ? addr_in : ~addr_in, go_in};
endmodule
`default_nettype wire

// ### tb/csd_decoder_tb_top.sv
// Purpose: Self-checking bench of the decoder
// Assumes: Selects one cycle after the bus cycle
// Notes:   Rows first, then reset cases
`timescale 1ns/1ns
`default_nettype none
module csd_decoder_tb_top
	import csd_pkg::*;
;
	logic         clk_in = 1'h0;
	logic         rst_n_in = 1'h0;
	logic         go = 1'h0;
	logic [31:0]  a = 32'h0;
	logic [31:0]  rdata;
	logic [3:0]   sel;
	csd_reg_req_t req = '0;
	csd_bus_cyc_t bus;
	int           err_count = 0;
	int           samples_checked = 0;
	// Address then expected select; region zero masks bits 23..14 and compares 31..24, region three masks bits 17..15
	logic [35:0]  rows [6] = '{36'hC0000000_1, 36'hC0FFFFFF_1, 36'hC1000000_0,
		36'h40000000_0, 36'h1FCBFFFF_8, 36'h1FC7FFFF_0};
	csd_bus_src i_csd_bus_src (.go_in(go), .addr_in(a), .bus_cyc_out(bus));
	csd_decoder i_csd_decoder (.clk_in, .rst_n_in, .reg_req_in(req),
		.reg_rdata_out(rdata), .bus_cyc_in(bus), .select_out(sel));
	// Clock
	initial forever #5 clk_in = ~clk_in;
	// Compare and count
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("MISMATCH %s exp %h got %h", n, e, g);
			err_count++;
		end
	endtask
	// Register access; a read checks the cycle after
	task automatic acc(input logic w, input logic [31:0] ad, input logic [31:0] d);
		@(posedge clk_in);
		req <= '{ad, d, w, !w};
		@(posedge clk_in);
		req <= '0;
		#1 if (!w) chk("rdata", d, rdata);
	endtask
	// One bus cycle, select checked one cycle later
	task automatic cyc(input logic [35:0] r);
		@(posedge clk_in);
		{a, go} <= {r[35:4], 1'h1};
		@(posedge clk_in);
		go <= 1'h0;
		#1 chk("select", 32'(r[3:0]), 32'(sel));
	endtask
	// Verdict
	task automatic test_done;
		if (err_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Program, sweep rows, then reset cases
	initial begin
		repeat (10) @(posedge clk_in);
		rst_n_in <= 1'h1;
		acc(1'h1, 32'hFFFFE400, 32'hC00003FF);
		acc(1'h1, 32'hFFFFE40C, 32'h1FC80007);
		acc(1'h1, 32'hFFFFE410, 32'h00000009);
		acc(1'h0, 32'hFFFFE400, 32'hC00003FF);
		acc(1'h0, 32'hFFFFE414, 32'h00000000);
		foreach (rows[i]) cyc(rows[i]);
		@(posedge clk_in);
		rst_n_in <= 1'h0;
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'h1;
		for (int i = 0; i < 4; i++) begin
			acc(1'h0, 32'hFFFFE400 + 32'(4 * i), i < 2 ? 32'h3FF : 32'h1FF);
		end
		cyc(36'hFFFFFFFF_4);
		test_done();
	end
endmodule
`default_nettype wire
